// File: pif_irq_flags.sv
// Peripheral interrupt flag bank 1 with its AXI4-Lite register slave.
// Assumes sources are synchronous to mclk_in and held high while asserted.
//
// Function
// - Each flag is set whenever its source asserts, regardless of the mask bit or global enable.
// - Bits 7 and 3 to 1 are absent, read as zero and ignore writes.
// - Bit 5 latches the first comparator's interrupt and reads zero when nothing is pending.
// - Bit 4 latches completion of a nonvolatile memory programming task and is clear otherwise.
// - Bit 0 latches each oscillator accumulator rollover and reads zero when none is pending.
`timescale 1ns/1ps
`default_nettype none
module pif_irq_flags #(
    parameter bit HAS_CMP2 = 1'b1 // Clear on the smaller variant without comparator 2
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    // AXI4-Lite write address channel
    input  wire logic [31:0] s_axil_awaddr_in,
    input  wire logic [2:0]  s_axil_awprot_in,
    input  wire logic        s_axil_awvalid_in,
    output logic             s_axil_awready_out,
    // AXI4-Lite write data channel
    input  wire logic [31:0] s_axil_wdata_in,
    input  wire logic [3:0]  s_axil_wstrb_in,
    input  wire logic        s_axil_wvalid_in,
    output logic             s_axil_wready_out,
    // AXI4-Lite write response channel
    output logic [1:0]       s_axil_bresp_out,
    output logic             s_axil_bvalid_out,
    input  wire logic        s_axil_bready_in,
    // AXI4-Lite read address channel
    input  wire logic [31:0] s_axil_araddr_in,
    input  wire logic [2:0]  s_axil_arprot_in,
    input  wire logic        s_axil_arvalid_in,
    output logic             s_axil_arready_out,
    // AXI4-Lite read data channel
    output logic [31:0]      s_axil_rdata_out,
    output logic [1:0]       s_axil_rresp_out,
    output logic             s_axil_rvalid_out,
    input  wire logic        s_axil_rready_in,
    // Interrupt sources from the peripherals
    input  wire logic        cmp1_irq_in,
    input  wire logic        cmp2_irq_in,
    input  wire logic        nvm_done_in,
    input  wire logic        osc_rollover_in,
    // Combined interrupt request
    output logic             irq_out
);
    import pif_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    pif_wr_e     wr_state;
    pif_rd_e     rd_state;
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [7:0]  flags;
    logic [7:0]  irq_mask;
    logic [0:0]  control;
    logic [7:0]  set_vec;

    ////////////////////////////////////////////////////////////////////////////
    // Source to flag mapping

    // Hardware sets come straight from the source levels, ungated by any enable
    assign set_vec[PIF_BIT_OSC]  = osc_rollover_in;
    assign set_vec[3:1]          = 3'h0;
    assign set_vec[PIF_BIT_NVM]  = nvm_done_in;
    assign set_vec[PIF_BIT_CMP1] = cmp1_irq_in;
    assign set_vec[PIF_BIT_CMP2] = HAS_CMP2 & cmp2_irq_in;
    assign set_vec[7]            = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Write path decode

    // A write may use an address or data taken earlier or in this very cycle,
    // which saves a cycle when the master offers both together
    logic        aw_hs;
    logic        w_hs;
    logic        have_aw;
    logic        have_w;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_fire;
    pif_sel_e    wr_sel;
    logic        wr_lane0;
    logic        flags_wr;
    logic        flags_clr;
    logic        mask_wr;
    logic        control_wr;
    logic [1:0]  wr_resp;

    assign aw_hs      = s_axil_awvalid_in & s_axil_awready_out;
    assign w_hs       = s_axil_wvalid_in & s_axil_wready_out;
    assign have_aw    = aw_held | aw_hs;
    assign have_w     = w_held | w_hs;
    assign wr_addr    = aw_held ? aw_addr : s_axil_awaddr_in;
    assign wr_data    = w_held ? w_data : s_axil_wdata_in;
    assign wr_strb    = w_held ? w_strb : s_axil_wstrb_in;
    assign wr_fire    = (wr_state == PIF_WR_COLLECT) & have_aw & have_w;
    assign wr_sel     = pif_decode(wr_addr);
    assign wr_lane0   = wr_strb[0]; // Registers sit in byte lane 0 only
    assign flags_wr   = wr_fire & wr_lane0 & (wr_sel == PIF_SEL_FLAGS);
    assign flags_clr  = wr_fire & wr_lane0 & (wr_sel == PIF_SEL_CLEAR);
    assign mask_wr    = wr_fire & wr_lane0 & (wr_sel == PIF_SEL_MASK);
    assign control_wr = wr_fire & wr_lane0 & (wr_sel == PIF_SEL_CONTROL);
    assign wr_resp    = (wr_sel == PIF_SEL_NONE) ? PIF_RESP_SLVERR : PIF_RESP_OKAY;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    // Flags: hardware set, software write and write-one-to-clear
    pif_flag_bank #(
        .W         (8),
        .IMPL_MASK (PIF_IMPL_MASK),
        .RST       (PIF_FLAGS_RST)
    ) u_flags (
        .mclk_in     (mclk_in),
        .rst_in      (rst_in),
        .set_in      (set_vec),
        .wr_en_in    (flags_wr),
        .wr_data_in  (wr_data[7:0]),
        .clr_en_in   (flags_clr),
        .clr_data_in (wr_data[7:0]),
        .flags_out   (flags)
    );

    // Interrupt enable mask, same layout as the flags
    pif_reg_word #(
        .W   (8),
        .RST (PIF_MASK_RST)
    ) u_mask (
        .mclk_in    (mclk_in),
        .rst_in     (rst_in),
        .wr_en_in   (mask_wr),
        .wr_data_in (wr_data[7:0] & PIF_IMPL_MASK),
        .q_out      (irq_mask)
    );

    // Global interrupt enable
    pif_reg_word #(
        .W   (1),
        .RST (PIF_CONTROL_RST)
    ) u_control (
        .mclk_in    (mclk_in),
        .rst_in     (rst_in),
        .wr_en_in   (control_wr),
        .wr_data_in (wr_data[PIF_BIT_GIE]),
        .q_out      (control)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write channel handshake

    // Ready drops as soon as an item is held, so the master never sees a
    // second address or data beat accepted before the response
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wr_state           <= PIF_WR_COLLECT;
            aw_held            <= 1'b0;
            w_held             <= 1'b0;
            aw_addr            <= 32'h0000_0000;
            w_data             <= 32'h0000_0000;
            w_strb             <= 4'h0;
            s_axil_awready_out <= 1'b1;
            s_axil_wready_out  <= 1'b1;
            s_axil_bvalid_out  <= 1'b0;
            s_axil_bresp_out   <= PIF_RESP_OKAY;
        end else begin
            case (wr_state)
                PIF_WR_COLLECT: begin
                    if (wr_fire) begin
                        wr_state           <= PIF_WR_RESP;
                        aw_held            <= 1'b0;
                        w_held             <= 1'b0;
                        s_axil_awready_out <= 1'b0;
                        s_axil_wready_out  <= 1'b0;
                        s_axil_bvalid_out  <= 1'b1;
                        s_axil_bresp_out   <= wr_resp;
                    end else begin
                        if (aw_hs) begin
                            aw_held            <= 1'b1;
                            aw_addr            <= s_axil_awaddr_in;
                            s_axil_awready_out <= 1'b0;
                        end
                        if (w_hs) begin
                            w_held            <= 1'b1;
                            w_data            <= s_axil_wdata_in;
                            w_strb            <= s_axil_wstrb_in;
                            s_axil_wready_out <= 1'b0;
                        end
                    end
                end
                PIF_WR_RESP: begin
                    if (s_axil_bready_in) begin
                        wr_state           <= PIF_WR_COLLECT;
                        s_axil_bvalid_out  <= 1'b0;
                        s_axil_awready_out <= 1'b1;
                        s_axil_wready_out  <= 1'b1;
                    end
                end
                default: begin
                    wr_state <= PIF_WR_COLLECT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path decode

    // Unused register bits and absent flag bits read as zero
    logic        ar_hs;
    pif_sel_e    rd_sel;
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;
    logic [7:0]  src_levels;

    assign ar_hs      = s_axil_arvalid_in & s_axil_arready_out;
    assign rd_sel     = pif_decode(s_axil_araddr_in);
    assign src_levels = set_vec;
    assign rd_word    = (rd_sel == PIF_SEL_FLAGS)   ? {24'h00_0000, flags} :
                        (rd_sel == PIF_SEL_CLEAR)   ? {24'h00_0000, flags} :
                        (rd_sel == PIF_SEL_MASK)    ? {24'h00_0000, irq_mask} :
                        (rd_sel == PIF_SEL_CONTROL) ? {31'h0000_0000, control} :
                        (rd_sel == PIF_SEL_SOURCES) ? {24'h00_0000, src_levels} :
                                                      32'h0000_0000;
    assign rd_resp    = (rd_sel == PIF_SEL_NONE) ? PIF_RESP_SLVERR : PIF_RESP_OKAY;

    ////////////////////////////////////////////////////////////////////////////
    // Read channel handshake

    // Read data are captured at the address handshake, so a flag set later
    // shows on the next read, not this one
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_state           <= PIF_RD_IDLE;
            s_axil_arready_out <= 1'b1;
            s_axil_rvalid_out  <= 1'b0;
            s_axil_rdata_out   <= 32'h0000_0000;
            s_axil_rresp_out   <= PIF_RESP_OKAY;
        end else begin
            case (rd_state)
                PIF_RD_IDLE: begin
                    if (ar_hs) begin
                        rd_state           <= PIF_RD_RESP;
                        s_axil_arready_out <= 1'b0;
                        s_axil_rvalid_out  <= 1'b1;
                        s_axil_rdata_out   <= rd_word;
                        s_axil_rresp_out   <= rd_resp;
                    end
                end
                PIF_RD_RESP: begin
                    if (s_axil_rready_in) begin
                        rd_state           <= PIF_RD_IDLE;
                        s_axil_rvalid_out  <= 1'b0;
                        s_axil_arready_out <= 1'b1;
                    end
                end
                default: begin
                    rd_state <= PIF_RD_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt output

    // Mask and global enable gate only the request, never the flags; a
    // stale flag fires at once when its mask bit is set, so software
    // clears it first
    logic next_irq;

    assign next_irq = control[0] & (|(flags & irq_mask));

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= next_irq;
        end
    end

endmodule
`default_nettype wire

// File: pif_pkg.sv
// Shared constants for the peripheral interrupt flag bank: register map,
// flag bit positions, reset values and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package pif_pkg;

    // Register byte offsets on the bus
    localparam logic [31:0] PIF_OFS_FLAGS   = 32'h0000_0000; // Flags, direct read/write
    localparam logic [31:0] PIF_OFS_MASK    = 32'h0000_0004; // Interrupt enable mask
    localparam logic [31:0] PIF_OFS_CLEAR   = 32'h0000_0008; // Write one to clear flags
    localparam logic [31:0] PIF_OFS_CONTROL = 32'h0000_000C; // Global interrupt enable
    localparam logic [31:0] PIF_OFS_SOURCES = 32'h0000_0010; // Live source levels

    // Flag bit positions
    localparam int PIF_BIT_OSC  = 0;
    localparam int PIF_BIT_NVM  = 4;
    localparam int PIF_BIT_CMP1 = 5;
    localparam int PIF_BIT_CMP2 = 6;
    localparam int PIF_BIT_GIE  = 0;

    // Implemented flag bits; bits 7 and 3..1 are absent
    localparam logic [7:0] PIF_IMPL_MASK   = 8'h71;
    localparam logic [7:0] PIF_FLAGS_RST   = 8'h00;
    localparam logic [7:0] PIF_MASK_RST    = 8'h00;
    localparam logic [0:0] PIF_CONTROL_RST = 1'h0;

    // AXI response codes
    localparam logic [1:0] PIF_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PIF_RESP_SLVERR = 2'h2;

    // Register selected by an address
    typedef enum logic [2:0] {
        PIF_SEL_FLAGS   = 3'b000,
        PIF_SEL_MASK    = 3'b001,
        PIF_SEL_CLEAR   = 3'b010,
        PIF_SEL_CONTROL = 3'b011,
        PIF_SEL_SOURCES = 3'b100,
        PIF_SEL_NONE    = 3'b111
    } pif_sel_e;

    // Write channel state
    typedef enum logic [0:0] {
        PIF_WR_COLLECT = 1'b0,
        PIF_WR_RESP    = 1'b1
    } pif_wr_e;

    // Read channel state
    typedef enum logic [0:0] {
        PIF_RD_IDLE = 1'b0,
        PIF_RD_RESP = 1'b1
    } pif_rd_e;

    // Address decode shared by the read and write paths
    function automatic pif_sel_e pif_decode(input logic [31:0] addr);
        pif_sel_e sel;
        sel = PIF_SEL_NONE;
        if (addr == PIF_OFS_FLAGS) sel = PIF_SEL_FLAGS;
        if (addr == PIF_OFS_MASK) sel = PIF_SEL_MASK;
        if (addr == PIF_OFS_CLEAR) sel = PIF_SEL_CLEAR;
        if (addr == PIF_OFS_CONTROL) sel = PIF_SEL_CONTROL;
        if (addr == PIF_OFS_SOURCES) sel = PIF_SEL_SOURCES;
        return sel;
    endfunction

endpackage

// File: pif_reg_word.sv
// Plain software register of parameterised width with a reset value.
// Assumes a synchronous active-high reset and a one-cycle write strobe.
`timescale 1ns/1ps
`default_nettype none
module pif_reg_word #(
    parameter int         W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    input  wire logic         wr_en_in,
    input  wire logic [W-1:0] wr_data_in,
    output logic      [W-1:0] q_out
);

    // Hold or load the word
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            q_out <= RST;
        end else if (wr_en_in) begin
            q_out <= wr_data_in;
        end
    end

endmodule
`default_nettype wire

// File: pif_flag_bank.sv
// Sticky hardware-set flag bank with software write and write-one-to-clear.
// Assumes set inputs are synchronous levels; absent bits are masked away.
`timescale 1ns/1ps
`default_nettype none
module pif_flag_bank #(
    parameter int           W         = 8,
    parameter logic [W-1:0] IMPL_MASK = '1,
    parameter logic [W-1:0] RST       = '0
) (
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] set_in,
    input  wire logic         wr_en_in,
    input  wire logic [W-1:0] wr_data_in,
    input  wire logic         clr_en_in,
    input  wire logic [W-1:0] clr_data_in,
    output logic      [W-1:0] flags_out
);

    logic [W-1:0] base;
    logic [W-1:0] clr_bits;
    logic [W-1:0] next_flags;

    // Software value first, then clears, then hardware sets; a set in the
    // same cycle as a clear or write wins so no event is lost
    assign base       = wr_en_in ? wr_data_in : flags_out;
    assign clr_bits   = clr_en_in ? clr_data_in : '0;
    assign next_flags = ((base & ~clr_bits) | set_in) & IMPL_MASK;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            flags_out <= RST;
        end else begin
            flags_out <= next_flags;
        end
    end

endmodule
`default_nettype wire

// File: pif_irq_flags_checker.sv
// Port-level checks for the interrupt flag bank.
// Assumes it is bound to pif_irq_flags and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pif_irq_flags_checker
    import pif_pkg::*;
#(
    parameter bit HAS_CMP2 = 1'b1
) (
    input wire logic        mclk_in,
    input wire logic        rst_in,
    input wire logic        s_axil_awvalid_in,
    input wire logic        s_axil_awready_out,
    input wire logic        s_axil_wvalid_in,
    input wire logic        s_axil_wready_out,
    input wire logic        s_axil_bvalid_out,
    input wire logic        s_axil_bready_in,
    input wire logic [31:0] s_axil_araddr_in,
    input wire logic        s_axil_arvalid_in,
    input wire logic        s_axil_arready_out,
    input wire logic [31:0] s_axil_rdata_out,
    input wire logic        s_axil_rvalid_out,
    input wire logic        s_axil_rready_in,
    input wire logic        cmp1_irq_in,
    input wire logic        cmp2_irq_in,
    input wire logic        nvm_done_in,
    input wire logic        osc_rollover_in,
    input wire logic        irq_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////
    // Handshakes; a flag read shows state from before its edge, so a source seen there must show
    wire logic ar_hs   = s_axil_arvalid_in && s_axil_arready_out;
    wire logic aw_hs   = s_axil_awvalid_in && s_axil_awready_out;
    wire logic w_hs    = s_axil_wvalid_in && s_axil_wready_out;
    wire logic flag_rd = ar_hs && (s_axil_araddr_in == PIF_OFS_FLAGS);

    cmp1_sets_a: assert property (flag_rd && $past(cmp1_irq_in) && !$past(rst_in) |=>
        s_axil_rdata_out[PIF_BIT_CMP1]) else $error("comparator 1 flag missing");
    cmp2_sets_a: assert property (HAS_CMP2 && flag_rd && $past(cmp2_irq_in) && !$past(rst_in) |=>
        s_axil_rdata_out[PIF_BIT_CMP2]) else $error("comparator 2 flag missing");
    nvm_sets_a: assert property (flag_rd && $past(nvm_done_in) && !$past(rst_in) |=>
        s_axil_rdata_out[PIF_BIT_NVM]) else $error("memory done flag missing");
    osc_sets_a: assert property (flag_rd && $past(osc_rollover_in) && !$past(rst_in) |=>
        s_axil_rdata_out[PIF_BIT_OSC]) else $error("rollover flag missing");
    absent_zero_a: assert property (flag_rd |=>
        (s_axil_rdata_out & ~{24'h0, PIF_IMPL_MASK}) == 32'h0) else $error("absent bits not zero");
    read_turn_a: assert property (ar_hs |=> s_axil_rvalid_out && !s_axil_arready_out)
        else $error("read answer late");
    rdata_hold_a: assert property (s_axil_rvalid_out && !s_axil_rready_in |=>
        s_axil_rvalid_out && $stable(s_axil_rdata_out)) else $error("read data dropped");
    write_resp_a: assert property (aw_hs && w_hs |=> s_axil_bvalid_out ##1
        (s_axil_bvalid_out || $past(s_axil_bready_in))) else $error("write response wrong");

    wr_c: cover property (aw_hs && w_hs);
    rd_c: cover property (flag_rd ##1 s_axil_rvalid_out);
    irq_c: cover property ($rose(irq_out));
endmodule

bind pif_irq_flags pif_irq_flags_checker #(.HAS_CMP2(HAS_CMP2)) u_pif_irq_flags_checker (
    .mclk_in, .rst_in, .s_axil_awvalid_in, .s_axil_awready_out, .s_axil_wvalid_in,
    .s_axil_wready_out, .s_axil_bvalid_out, .s_axil_bready_in, .s_axil_araddr_in,
    .s_axil_arvalid_in, .s_axil_arready_out, .s_axil_rdata_out, .s_axil_rvalid_out,
    .s_axil_rready_in, .cmp1_irq_in, .cmp2_irq_in, .nvm_done_in, .osc_rollover_in, .irq_out);
`default_nettype wire

// File: tb_pif_irq_flags.sv
// Self-checking bench for the interrupt flag bank over AXI4-Lite.
// Assumes pif_pkg, the design and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_pif_irq_flags;
    import pif_pkg::*;
    logic        mclk_in = 1'b0;
    logic        rst_in  = 1'b1;
    logic [31:0] awaddr  = '0, wdata = '0, araddr = '0, rdat, rword;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  src     = '0; // Rollover, memory done, comparator 1, comparator 2
    logic [3:0]  wstrb   = 4'hF;
    int          pos [4] = '{PIF_BIT_OSC, PIF_BIT_NVM, PIF_BIT_CMP1, PIF_BIT_CMP2};
    int          err_total = 0, checked = 0, i;

    pif_irq_flags u_pif_irq_flags (.mclk_in(mclk_in), .rst_in(rst_in),
        .s_axil_awaddr_in(awaddr), .s_axil_awprot_in(3'h0), .s_axil_awvalid_in(awvalid),
        .s_axil_awready_out(awready), .s_axil_wdata_in(wdata), .s_axil_wstrb_in(wstrb),
        .s_axil_wvalid_in(wvalid), .s_axil_wready_out(wready), .s_axil_bresp_out(bresp),
        .s_axil_bvalid_out(bvalid), .s_axil_bready_in(bready), .s_axil_araddr_in(araddr),
        .s_axil_arprot_in(3'h0), .s_axil_arvalid_in(arvalid), .s_axil_arready_out(arready),
        .s_axil_rdata_out(rdat), .s_axil_rresp_out(rresp), .s_axil_rvalid_out(rvalid),
        .s_axil_rready_in(rready), .cmp1_irq_in(src[2]), .cmp2_irq_in(src[3]),
        .nvm_done_in(src[1]), .osc_rollover_in(src[0]), .irq_out(irq));

    ////////////////////////////////////////
    // Clock, compare and closing report
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic hung();
        err_total++;
        $display("mismatch at %0t: wait ran out", $time);
        print_verdict();
    endtask

    ////////////////////////////////////////
    // Bus master; ready is raised a cycle late so the slave must hold its answer
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge mclk_in);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (bvalid && bready) begin
                r = bresp;
                done = 1'b1;
                bready <= 1'b0;
            end else if (bvalid) begin
                bready <= 1'b1;
            end
        end
        if (!done) begin
            hung();
        end
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge mclk_in);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid && rready) begin
                d = rdat;
                r = rresp;
                done = 1'b1;
                rready <= 1'b0;
            end else if (rvalid) begin
                rready <= 1'b1;
            end
        end
        if (!done) begin
            hung();
        end
    endtask

    task automatic wrc(input logic [31:0] a, input logic [31:0] d);
        wr(a, d, resp);
        chk({30'h0, resp}, {30'h0, PIF_RESP_OKAY});
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d, resp);
        chk(d, exp);
        chk({30'h0, resp}, {30'h0, PIF_RESP_OKAY});
    endtask

    task automatic pulse(input int k);
        src[k] <= 1'b1;
        @(posedge mclk_in);
        src[k] <= 1'b0;
        @(posedge mclk_in);
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        chk({31'h0, irq}, 32'h0);
        rdc(PIF_OFS_FLAGS, {24'h0, PIF_FLAGS_RST});
        rdc(PIF_OFS_MASK, {24'h0, PIF_MASK_RST});
        rdc(PIF_OFS_CONTROL, {31'h0, PIF_CONTROL_RST});
        // Software fills every bit; absent ones must stay zero
        wrc(PIF_OFS_FLAGS, 32'hFFFF_FFFF);
        rdc(PIF_OFS_FLAGS, {24'h0, PIF_IMPL_MASK});
        wrc(PIF_OFS_MASK, 32'h0000_00FF);
        rdc(PIF_OFS_MASK, {24'h0, PIF_IMPL_MASK});
        wrc(PIF_OFS_MASK, 32'h0);
        wrc(PIF_OFS_CLEAR, 32'h0000_00FF);
        rdc(PIF_OFS_FLAGS, 32'h0);
        // One-cycle pulse per source with every enable off
        for (i = 0; i < 4; i++) begin
            pulse(i);
            rdc(PIF_OFS_FLAGS, 32'h1 << pos[i]);
            chk({31'h0, irq}, 32'h0);
            wrc(PIF_OFS_CLEAR, 32'h1 << pos[i]);
            rdc(PIF_OFS_FLAGS, 32'h0);
        end
        // A live source beats a software clear
        src[2] <= 1'b1;
        wrc(PIF_OFS_CLEAR, 32'h1 << PIF_BIT_CMP1);
        rdc(PIF_OFS_FLAGS, 32'h1 << PIF_BIT_CMP1);
        rdc(PIF_OFS_SOURCES, 32'h1 << PIF_BIT_CMP1);
        rdc(PIF_OFS_CLEAR, 32'h1 << PIF_BIT_CMP1);
        src[2] <= 1'b0;
        wrc(PIF_OFS_CLEAR, 32'h1 << PIF_BIT_CMP1);
        // Stale flag cleared before enabling, so no request appears
        pulse(1);
        wrc(PIF_OFS_CLEAR, 32'h1 << PIF_BIT_NVM);
        wrc(PIF_OFS_MASK, 32'h0000_0030);
        wrc(PIF_OFS_CONTROL, 32'h1);
        repeat (3) @(posedge mclk_in);
        chk({31'h0, irq}, 32'h0);
        pulse(2);
        repeat (2) @(posedge mclk_in);
        chk({31'h0, irq}, 32'h1);
        wrc(PIF_OFS_MASK, 32'h0000_0010);
        repeat (2) @(posedge mclk_in);
        chk({31'h0, irq}, 32'h0);
        wrc(PIF_OFS_MASK, 32'h0000_0030);
        wrc(PIF_OFS_CLEAR, 32'h1 << PIF_BIT_CMP1);
        repeat (2) @(posedge mclk_in);
        chk({31'h0, irq}, 32'h0);
        // Reset in mid-run with a request pending drops every flag and enable
        pulse(2);
        repeat (2) @(posedge mclk_in);
        chk({31'h0, irq}, 32'h1);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        chk({31'h0, irq}, 32'h0);
        rdc(PIF_OFS_FLAGS, {24'h0, PIF_FLAGS_RST});
        rdc(PIF_OFS_MASK, {24'h0, PIF_MASK_RST});
        rdc(PIF_OFS_CONTROL, {31'h0, PIF_CONTROL_RST});
        // Byte lane 0 off: the write is answered but changes nothing
        wstrb <= 4'h0;
        wrc(PIF_OFS_MASK, 32'h0000_00FF);
        wstrb <= 4'hF;
        rdc(PIF_OFS_MASK, {24'h0, PIF_MASK_RST});
        // Unmapped place
        wr(32'h0000_0014, 32'h1, resp);
        chk({30'h0, resp}, {30'h0, PIF_RESP_SLVERR});
        rd(32'h0000_0014, rword, resp);
        chk(rword, 32'h0);
        chk({30'h0, resp}, {30'h0, PIF_RESP_SLVERR});
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge mclk_in);
        hung();
    end
endmodule
`default_nettype wire
